// ==== fbm_pkg.sv ====
// constants, register map and timing for the flash bus controller
`default_nettype none
package fbm_pkg;
    // clock period of hclk
    localparam int CLK_NS = 50;

    // least time in ns to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // flash timing in its own units
    localparam int RESET_PULSE_MIN_NS = 100;
    localparam int READ_WAKE_NS = 150;
    localparam int WRITE_WAKE_NS = 150;
    localparam int READ_ACCESS_NS = 100;
    localparam int WRITE_PULSE_NS = 100;
    localparam int ABORT_ERASE_US = 22;
    localparam int ABORT_PROG_US = 12;

    // derived cycle counts
    localparam int TW = 10;
    localparam logic [TW-1:0] RESET_CYC = TW'(ns_to_cyc(RESET_PULSE_MIN_NS));
    localparam logic [TW-1:0] READ_WAKE_CYC = TW'(ns_to_cyc(READ_WAKE_NS));
    localparam logic [TW-1:0] WRITE_WAKE_CYC = TW'(ns_to_cyc(WRITE_WAKE_NS));
    localparam logic [TW-1:0] READ_ACC_CYC = TW'(ns_to_cyc(READ_ACCESS_NS));
    localparam logic [TW-1:0] WRITE_PULSE_CYC = TW'(ns_to_cyc(WRITE_PULSE_NS));
    localparam logic [TW-1:0] ABORT_ERASE_CYC = TW'(ns_to_cyc(ABORT_ERASE_US * 1000));
    localparam logic [TW-1:0] ABORT_PROG_CYC = TW'(ns_to_cyc(ABORT_PROG_US * 1000));

    // flash bus widths
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;

    // controller register offsets (byte addresses)
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // field layout
    localparam int CMD_OP_W = 3;
    localparam int ST_BUSY = 0;
    localparam int ST_RD_RDY = 1;
    localparam int ST_WR_RDY = 2;
    localparam int ST_MODE_LSB = 3;
    localparam int ST_IN_RST = 5;

    // operations started through REG_CMD
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_WRITE = 3'h2;
    localparam logic [2:0] OP_ARRAY = 3'h3;
    localparam logic [2:0] OP_IDENT = 3'h4;
    localparam logic [2:0] OP_RESET = 3'h5;
    localparam logic [2:0] OP_ABORT_PROG = 3'h6;
    localparam logic [2:0] OP_ABORT_ERASE = 3'h7;

    // read mode the flash is believed to be in
    localparam logic [1:0] MODE_UNKNOWN = 2'h0;
    localparam logic [1:0] MODE_ARRAY = 2'h1;
    localparam logic [1:0] MODE_IDENT = 2'h2;

    // command codes written to the command front end
    localparam logic [15:0] CODE_READ_ARRAY = 16'h00FF;
    localparam logic [15:0] CODE_READ_IDENT = 16'h0090;

    // identifier-mode map, offsets added to a block base address
    localparam logic [7:0] ID_OFS_MAKER = 8'h00;
    localparam logic [7:0] ID_OFS_PART = 8'h01;
    localparam logic [7:0] ID_OFS_PROTECT = 8'h02;
    localparam logic [7:0] ID_OFS_OTP_LOCK = 8'h80;
    localparam logic [7:0] ID_OFS_OTP_FIRST = 8'h81;
    localparam logic [7:0] ID_OFS_OTP_LAST = 8'h88;
    localparam int PROT_LOCKED_BIT = 0;
    localparam int PROT_LOCKDOWN_BIT = 1;
    localparam logic [7:0] FLASH_SR_AFTER_RESET = 8'h80;
endpackage
`default_nettype wire

// ==== fbm_wake_timer.sv ====
// wake-up timer: counts a fixed delay after hold is released
`timescale 1ns/1ns
`default_nettype none
module fbm_wake_timer
    import fbm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // control
    input wire logic hold,
    input wire logic [TW-1:0] limit,
    // result
    output logic expired
);
    logic [TW-1:0] cnt_reg;

    // reload while held, then count down once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= '0;
            expired <= 1'b0;
        end else if (clk_en) begin
            if (hold) begin
                cnt_reg <= limit;
                expired <= 1'b0;
            end else if (!expired) begin
                if (cnt_reg <= 1) begin
                    expired <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== fbm_ctrl.sv ====
// host controller for a parallel nor flash, driven from an ahb-lite register port
// Summary of operation
// - reads drive reset high, select low, output enable low, write strobe high.
// - writes drive select and write strobe low, reset and output enable high.
// - host waits read and write wake delays after raising reset.
// - after abort, wake delays count from end of shutdown interval.
// - flash reset follows the controller reset.
// - write 0xFF to return to read-array mode before array reads; OP_READ starts in any mode_reg state without writing it.
// - 0x90 enters identifier mode; 0xFF leaves it.
// - reset pulse lasts at least 100 ns.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module fbm_ctrl
    import fbm_pkg::*;
(
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // flash pins
    output logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] flash_dq_in,
    output logic [DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_powerdown_n
);
    typedef enum logic [2:0] {
        S_RST, S_SHUT, S_IDLE, S_RD_ACC, S_WR_SET, S_WR_PULSE, S_WR_HOLD
    } fbm_state_t;

    fbm_state_t st_reg;
    logic [TW-1:0] cnt_reg;
    logic [2:0] op_reg;
    logic [1:0] mode_reg;
    logic abort_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic ap_valid_reg;
    logic ap_write_reg;
    logic [7:0] ap_addr_reg;
    logic rd_rdy;
    logic wr_rdy;
    logic wake_hold;
    logic busy;
    logic take;
    logic wr_en;
    logic [31:0] rd_mux;
    logic [DATA_W-1:0] wr_word;

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave

    assign take = hsel && htrans[1] && hready;
    assign wr_en = ap_valid_reg && ap_write_reg;
    assign busy = (st_reg != S_IDLE) || (op_reg != OP_NONE);

    // address phase capture; zero wait states, so ready never drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            ap_valid_reg <= take;
            ap_write_reg <= hwrite;
            ap_addr_reg <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read decode; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (haddr[7:0] == REG_ADDR) begin
            rd_mux[ADDR_W-1:0] = addr_reg;
        end else if (haddr[7:0] == REG_WDATA) begin
            rd_mux[DATA_W-1:0] = wdata_reg;
        end else if (haddr[7:0] == REG_RDATA) begin
            rd_mux[DATA_W-1:0] = rdata_reg;
        end else if (haddr[7:0] == REG_STATUS) begin
            rd_mux[ST_BUSY] = busy;
            rd_mux[ST_RD_RDY] = rd_rdy;
            rd_mux[ST_WR_RDY] = wr_rdy;
            rd_mux[ST_MODE_LSB +: 2] = mode_reg;
            rd_mux[ST_IN_RST] = !flash_reset_powerdown_n;
        end
    end

    // read data is registered during the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && take && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // software address and write data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= '0;
            wdata_reg <= '0;
        end else if (clk_en && wr_en) begin
            if (ap_addr_reg == REG_ADDR) begin
                addr_reg <= hwdata[ADDR_W-1:0];
            end else if (ap_addr_reg == REG_WDATA) begin
                wdata_reg <= hwdata[DATA_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake-up delays after reset release or after abort shutdown

    assign wake_hold = (st_reg == S_RST) || (st_reg == S_SHUT);

    fbm_wake_timer u_rd_wake (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .hold(wake_hold),
        .limit(READ_WAKE_CYC),
        .expired(rd_rdy)
    );

    fbm_wake_timer u_wr_wake (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .hold(wake_hold),
        .limit(WRITE_WAKE_CYC),
        .expired(wr_rdy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pin sequencer

    // word on the data pins: command code or software data
    always_comb begin
        wr_word = wdata_reg;
        if (op_reg == OP_ARRAY) begin
            wr_word = CODE_READ_ARRAY;
        end else if (op_reg == OP_IDENT) begin
            wr_word = CODE_READ_IDENT;
        end
    end

    // flash reset follows hresetn: pins start with reset asserted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= S_RST;
            cnt_reg <= RESET_CYC;
            op_reg <= OP_NONE;
            abort_reg <= 1'b0;
            mode_reg <= MODE_UNKNOWN;
            rdata_reg <= '0;
            flash_addr <= '0;
            flash_dq_out <= '0;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_reset_powerdown_n <= 1'b0;
        end else if (clk_en) begin
            case (st_reg)
                S_RST: begin
                    // hold reset for the minimum pulse, then release
                    if (cnt_reg <= 1) begin
                        flash_reset_powerdown_n <= 1'b1;
                        if (abort_reg) begin
                            cnt_reg <= (op_reg == OP_ABORT_PROG) ? ABORT_PROG_CYC : ABORT_ERASE_CYC;
                            st_reg <= S_SHUT;
                        end else begin
                            mode_reg <= MODE_ARRAY;
                            op_reg <= OP_NONE;
                            st_reg <= S_IDLE;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                S_SHUT: begin
                    // the flash is still stopping the aborted operation
                    if (cnt_reg <= 1) begin
                        mode_reg <= MODE_ARRAY;
                        abort_reg <= 1'b0;
                        op_reg <= OP_NONE;
                        st_reg <= S_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                S_IDLE: begin
                    // a new order is taken only while idle; busy ones are dropped
                    if (op_reg == OP_NONE) begin
                        if (wr_en && ap_addr_reg == REG_CMD) begin
                            op_reg <= hwdata[CMD_OP_W-1:0];
                        end
                    end else if (op_reg == OP_READ) begin
                        if (rd_rdy) begin
                            flash_addr <= addr_reg;
                            flash_ce_n <= 1'b0;
                            flash_oe_n <= 1'b0;
                            cnt_reg <= READ_ACC_CYC;
                            st_reg <= S_RD_ACC;
                        end
                    end else if (op_reg >= OP_RESET) begin
                        // mid-operation reset aborts it; target data is lost
                        flash_reset_powerdown_n <= 1'b0;
                        abort_reg <= (op_reg != OP_RESET);
                        cnt_reg <= RESET_CYC;
                        st_reg <= S_RST;
                    end else if (wr_rdy) begin
                        flash_addr <= addr_reg;
                        flash_dq_out <= wr_word;
                        flash_dq_oe <= 1'b1;
                        flash_ce_n <= 1'b0;
                        st_reg <= S_WR_SET;
                    end
                end
                S_RD_ACC: begin
                    // data sampled as output enable and select rise
                    if (cnt_reg <= 1) begin
                        rdata_reg <= flash_dq_in;
                        flash_oe_n <= 1'b1;
                        flash_ce_n <= 1'b1;
                        op_reg <= OP_NONE;
                        st_reg <= S_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                S_WR_SET: begin
                    // address and data settle one cycle before the strobe
                    flash_we_n <= 1'b0;
                    cnt_reg <= WRITE_PULSE_CYC;
                    st_reg <= S_WR_PULSE;
                end
                S_WR_PULSE: begin
                    // strobe rises while select is still low, so it latches
                    if (cnt_reg <= 1) begin
                        flash_we_n <= 1'b1;
                        st_reg <= S_WR_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                S_WR_HOLD: begin
                    flash_ce_n <= 1'b1;
                    flash_dq_oe <= 1'b0;
                    op_reg <= OP_NONE;
                    st_reg <= S_IDLE;
                    // a raw write may start program or erase, mode becomes unknown
                    if (op_reg == OP_ARRAY) begin
                        mode_reg <= MODE_ARRAY;
                    end else if (op_reg == OP_IDENT) begin
                        mode_reg <= MODE_IDENT;
                    end else begin
                        mode_reg <= MODE_UNKNOWN;
                    end
                end
                default: begin
                    st_reg <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks on the pins this controller drives

    property p_read_pins;
        @(posedge hclk) disable iff (!hresetn)
        !flash_oe_n |-> !flash_ce_n && flash_we_n && flash_reset_powerdown_n && !flash_dq_oe;
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("bad pin state during read");

    property p_write_pins;
        @(posedge hclk) disable iff (!hresetn)
        !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_reset_powerdown_n && flash_dq_oe;
    endproperty
    a_write_pins: assert property (p_write_pins) else $error("bad pin state during write");

    property p_no_contention;
        @(posedge hclk) disable iff (!hresetn)
        flash_dq_oe |-> flash_oe_n;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("data driven while outputs on");

    property p_strobe_first;
        @(posedge hclk) disable iff (!hresetn)
        $rose(flash_we_n) |-> !flash_ce_n && flash_dq_oe ##1 flash_ce_n;
    endproperty
    a_strobe_first: assert property (p_strobe_first) else $error("select rose before strobe");

    property p_reset_pulse;
        @(posedge hclk) disable iff (!hresetn)
        $fell(flash_reset_powerdown_n) |-> !flash_reset_powerdown_n [*2];
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too short");

    property p_read_wake;
        @(posedge hclk) disable iff (!hresetn)
        $rose(flash_reset_powerdown_n) |-> flash_oe_n [*3];
    endproperty
    a_read_wake: assert property (p_read_wake) else $error("read before wake delay");

    property p_write_wake;
        @(posedge hclk) disable iff (!hresetn)
        $rose(flash_reset_powerdown_n) |-> flash_we_n [*3];
    endproperty
    a_write_wake: assert property (p_write_wake) else $error("write before wake delay");

    property p_shut_quiet;
        @(posedge hclk) disable iff (!hresetn)
        st_reg == S_SHUT |-> !rd_rdy && !wr_rdy && flash_oe_n && flash_we_n;
    endproperty
    a_shut_quiet: assert property (p_shut_quiet) else $error("access during abort shutdown");

    property p_array_code;
        @(posedge hclk) disable iff (!hresetn)
        !flash_we_n && op_reg == OP_ARRAY |-> flash_dq_out == 16'h00FF;
    endproperty
    a_array_code: assert property (p_array_code) else $error("wrong read-array code");

    property p_ident_mode;
        @(posedge hclk) disable iff (!hresetn)
        $rose(flash_we_n) && op_reg == OP_IDENT && clk_en |=> mode_reg == MODE_IDENT;
    endproperty
    a_ident_mode: assert property (p_ident_mode) else $error("identifier mode not tracked");
endmodule
`default_nettype wire

// ==== fbm_flash_model.sv ====
// behavioural parallel nor flash that answers the controller's pins
`timescale 1ns/1ns
`default_nettype none
module fbm_flash_model
    import fbm_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h5A01, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h3C02 // arbitrary value
)(
    // pins from the controller
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_from_host,
    input wire logic dq_host_oe,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_powerdown_n,
    // pins to the controller, and a count of host misbehaviour
    output logic [DATA_W-1:0] dq_to_host,
    output var int viol_cnt
);
    logic ident_mode;
    logic drive;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] last_q;
    realtime wake_at;
    realtime fell_at;
    initial begin
        viol_cnt = 0;
        ident_mode = 1'b0;
        last_q = 16'h0000;
        wake_at = 0;
        fell_at = 0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // leaving reset always lands in read-array mode
    always @(negedge reset_powerdown_n) fell_at = $realtime;
    always @(posedge reset_powerdown_n) begin
        if ($realtime - fell_at < RESET_PULSE_MIN_NS) viol_cnt++;
        ident_mode = 1'b0;
        wake_at = $realtime;
    end
    // command latched on whichever strobe rises first; oe_n low still counts as write
    // a rising select only closes the latch window, it stops nothing inside
    always @(posedge we_n or posedge ce_n) begin
        if (reset_powerdown_n && (ce_n ^ we_n)) begin
            if ($realtime - wake_at < WRITE_WAKE_NS) viol_cnt++;
            // unknown codes leave the array untouched
            case (dq_from_host)
                CODE_READ_ARRAY: ident_mode = 1'b0;
                CODE_READ_IDENT: ident_mode = 1'b1;
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // output drivers only in a clean read cycle
    assign drive = reset_powerdown_n && !ce_n && !oe_n && we_n;
    always @* begin
        if (!ident_mode) rd_word = addr[15:0] ^ 16'hA5C3;
        else if (addr[7:0] == ID_OFS_MAKER) rd_word = MAKER_CODE;
        else if (addr[7:0] == ID_OFS_PART) rd_word = PART_CODE;
        else if (addr[7:0] == ID_OFS_PROTECT) rd_word = 16'h0001;
        else if (addr[7:0] == ID_OFS_OTP_LOCK) rd_word = 16'h0002;
        else rd_word = {8'hE0, addr[7:0]};
    end
    always @(drive or rd_word) if (drive) last_q = rd_word;
    always @(posedge drive) if ($realtime - wake_at < READ_WAKE_NS) viol_cnt++;
    always @(drive or dq_host_oe) if (drive && dq_host_oe) viol_cnt++;
    // released bus shows the inverse of the last word, never a lucky match
    assign dq_to_host = drive ? rd_word : (dq_host_oe ? dq_from_host : ~last_q);
endmodule
`default_nettype wire

// ==== fbm_ctrl_test.sv ====
// self-checking bench for the flash bus controller
`timescale 1ns/1ns
`default_nettype none
module fbm_ctrl_test;
    import fbm_pkg::*;
    localparam logic [15:0] MAKER = 16'h5A01; // arbitrary value
    localparam logic [15:0] PART = 16'h3C02; // arbitrary value
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [ADDR_W-1:0] f_addr, a;
    logic [DATA_W-1:0] f_dq_in, f_dq_out;
    logic f_oe, f_ce_n, f_oe_n, f_we_n, f_reset_powerdown_n, clk_en;
    logic [7:0] o;
    int viol, err_total, n_tests, cyc, lim;
    logic [31:0] exp_q[$], obs_q[$];
    event obs_ev;

    fbm_ctrl i_fbm_ctrl(.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .flash_addr(f_addr), .flash_dq_in(f_dq_in),
        .flash_dq_out(f_dq_out), .flash_dq_oe(f_oe), .flash_ce_n(f_ce_n), .flash_oe_n(f_oe_n),
        .flash_we_n(f_we_n), .flash_reset_powerdown_n(f_reset_powerdown_n));
    fbm_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_fbm_flash_model(.addr(f_addr),
        .dq_from_host(f_dq_out), .dq_host_oe(f_oe), .ce_n(f_ce_n), .oe_n(f_oe_n), .we_n(f_we_n),
        .reset_powerdown_n(f_reset_powerdown_n), .dq_to_host(f_dq_in), .viol_cnt(viol));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // compare and verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (exp_q.size() != 0) err_total++;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // the watcher pairs every observed result with the oldest note
    initial forever begin
        @(obs_ev);
        // drain all, so two notes in one time step both get compared
        while (obs_q.size() > 0) check(obs_q.pop_front(), exp_q.pop_front());
    end
    task automatic note(input logic [31:0] got, input logic [31:0] exp);
        exp_q.push_back(exp);
        obs_q.push_back(got);
        -> obs_ev;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // one ahb-lite single transfer; entered just after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        htrans <= 2'b10;
        hsel <= 1'b1;
        k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
        rd = hrdata;
        if (k >= 100) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        logic [31:0] x;
        ahb(1'b1, ad, wd, x);
    endtask
    task automatic chk_rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, ad, 32'h0, x);
        note(x & m, e & m);
    endtask
    // poll status until the masked bits are all clear; bounded
    task automatic poll(input logic [31:0] m, output int c);
        logic [31:0] s;
        c = 0;
        do begin ahb(1'b0, REG_STATUS, 32'h0, s); c += 2; end while ((s & m) !== 32'h0 && c < 2000);
        if (c >= 2000) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic run_op(input logic [2:0] op, output int c);
        wr(REG_CMD, {29'h0, op});
        poll(32'h1, c);
    endtask
    task automatic mode_is(input logic [1:0] m);
        chk_rd(REG_STATUS, 32'h18, {27'h0, m, 3'h0});
    endtask
    function automatic logic [15:0] id_exp(input logic [7:0] of);
        case (of)
            8'h00: return MAKER;
            8'h01: return PART;
            8'h02: return 16'h0001;
            8'h80: return 16'h0002;
            default: return {8'hE0, of};
        endcase
    endfunction
    task automatic rd_flash(input logic [ADDR_W-1:0] fa, input logic [15:0] e);
        wr(REG_ADDR, {11'h0, fa});
        run_op(OP_READ, cyc);
        chk_rd(REG_RDATA, 32'hFFFF, {16'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        hresetn = 1'b0;
        clk_en = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        err_total = 0;
        n_tests = 0;
        void'($urandom(32'hD1CC0EE5));
        repeat (5) @(posedge hclk);
        note({27'h0, f_reset_powerdown_n, f_ce_n, f_oe_n, f_we_n, f_oe}, 32'h0E);
        hresetn <= 1'b1;
        @(posedge hclk);
        poll(32'h20, cyc);
        repeat (4) @(posedge hclk);
        chk_rd(REG_STATUS, 32'h3F, 32'h0E);
        // array reads at random places, with address readback
        repeat (3) begin
            a = ADDR_W'($urandom);
            rd_flash(a, a[15:0] ^ 16'hA5C3);
            chk_rd(REG_ADDR, 32'h1FFFFF, {11'h0, a});
        end
        wr(8'h14, $urandom);
        chk_rd(8'h14, 32'hFFFFFFFF, 32'h0);
        chk_rd(REG_CMD, 32'hFFFFFFFF, 32'h0);
        // raw write of a non-command word leaves the array as it was
        d = $urandom & 32'h7F7F;
        wr(REG_WDATA, d);
        chk_rd(REG_WDATA, 32'hFFFF, d);
        run_op(OP_WRITE, cyc);
        mode_is(MODE_UNKNOWN);
        rd_flash(a, a[15:0] ^ 16'hA5C3);
        // identifier map at a random block base
        run_op(OP_IDENT, cyc);
        mode_is(MODE_IDENT);
        a = ADDR_W'($urandom) & 21'h1F8000;
        for (int i = 0; i < 12; i++) begin
            o = (i < 3) ? 8'(i) : 8'(8'h7D + i);
            rd_flash(a | {13'h0, o}, id_exp(o));
        end
        run_op(OP_ARRAY, cyc);
        mode_is(MODE_ARRAY);
        rd_flash(a, a[15:0] ^ 16'hA5C3);
        // a command while busy is ignored; reset leaves identifier mode
        run_op(OP_IDENT, cyc);
        wr(REG_CMD, {29'h0, OP_RESET});
        wr(REG_CMD, {29'h0, OP_IDENT});
        poll(32'h1, cyc);
        repeat (4) @(posedge hclk);
        mode_is(MODE_ARRAY);
        rd_flash(a, a[15:0] ^ 16'hA5C3);
        // both aborts wait out their shutdown before the next access
        for (int i = 0; i < 2; i++) begin
            run_op(i == 0 ? OP_ABORT_PROG : OP_ABORT_ERASE, cyc);
            lim = (i == 0) ? int'(ABORT_PROG_CYC) : int'(ABORT_ERASE_CYC);
            note({31'h0, cyc >= lim && cyc <= lim + 10}, 32'h1);
            repeat (4) @(posedge hclk);
            mode_is(MODE_ARRAY);
            rd_flash(a, a[15:0] ^ 16'hA5C3);
        end
        // a frozen enable holds every flop, so a reset order taken just before must wait
        wr(REG_CMD, {29'h0, OP_RESET});
        clk_en <= 1'b0;
        repeat (8) @(posedge hclk);
        note({31'h0, f_reset_powerdown_n}, 32'h1);
        clk_en <= 1'b1;
        poll(32'h1, cyc);
        repeat (4) @(posedge hclk);
        mode_is(MODE_ARRAY);
        note({30'h0, hreadyout, hresp}, 32'h2);
        note(viol, 32'h0);
        @(posedge hclk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
